/* verilog/frc_consts.vh */
// Constants for the flash register command handler.
`ifndef FRC_CONSTS_VH
`define FRC_CONSTS_VH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define FRC_CMD_WREN 8'h06
`define FRC_CMD_RDSR 8'h05
`define FRC_CMD_WRSR 8'h01
`define FRC_CMD_RDFSR 8'h70
`define FRC_CMD_RDVCR 8'h85
`define FRC_CMD_WRVCR 8'h81
`define FRC_CMD_RDEVCR 8'h65
`define FRC_CMD_WREVCR 8'h61
`define FRC_CMD_RDNVCR 8'hb5
`define FRC_CMD_WRNVCR 8'hb1
`define FRC_CMD_RDEAR 8'hc8
`define FRC_CMD_WREAR 8'hc5
`define FRC_CMD_RDLOCK 8'he8
`define FRC_CMD_WRLOCK 8'he5
// ----------------------------------------
// Reset values, field masks and positions
// ----------------------------------------
`define FRC_SR_RST 8'h00
`define FRC_SR_WMASK 8'hfc
`define FRC_VCR_RST 8'hfb
`define FRC_VCR_WMASK 8'hfb
`define FRC_EVCR_RST 8'hdf
`define FRC_EAR_RST 8'h00
`define FRC_EAR_WMASK 8'h01
`define FRC_NVCR_RST 16'hffff
`define FRC_FSR_PEC_BIT 7
`define FRC_LOCK_DOWN_BIT 1
`define FRC_LOCK_WRITE_BIT 0
`define FRC_SR_WEL_BIT 1
`define FRC_SR_WIP_BIT 0
// ----------------------------------------
// Timing: clock 100 ns; times in ns
// ----------------------------------------
`define FRC_CLK_NS 100
`define FRC_STATUS_WRITE_TIME_NS 1300000
`define FRC_NONVOLATILE_CFG_WRITE_TIME_NS 3000000
`define FRC_STATUS_WRITE_CYC ((`FRC_STATUS_WRITE_TIME_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`define FRC_NVCFG_WRITE_CYC \
  ((`FRC_NONVOLATILE_CFG_WRITE_TIME_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`endif

/* verilog/frc_busy_timer.v */
// Self-timed busy counter for status and nonvolatile configuration writes.
module frc_busy_timer #(
  parameter CW = 24
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [CW-1:0] load,
  output reg busy_q
);
  // Remaining cycles of the current self-timed operation.
  reg [CW-1:0] cnt_q;

  // Load on start, count down to zero, then drop busy.
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= {CW{1'b0}};
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
        busy_q <= 1'b0;
        cnt_q <= {CW{1'b0}};
      end else begin
        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* verilog/frc_top.v */
// Register command handler of a serial NOR flash behind its SPI pins.
`include "frc_consts.vh"

// Overview of operation
// - Single, dual, quad line widths both directions.
// - Continuous reads repeat the same register byte.
// - Chip select high ends read, releases lines.
// - Writes ignored unless write enable latch set.
// - Status write starts timed busy on deselect.
// - Status write changes only bits 7:2.
// - Protect pin gates status register writes.
// - Controller flag zero while timed write runs.
// - Nonvolatile write: sixteen bits, then timed busy.
// - Volatile register writes apply immediately.
// - Reserved bits keep value on writes.
// - Reset-pin variant skips enable for address writes.
// - Lock read takes address bits on rising edge.
// - Lock data shifts out on falling edges.
// - Lock read rejected while a cycle runs.
// - Lock-down bit clear at power-up, freezes lock bits.
// - Sector write lock blocks program and erase.
// - Controller flag is flag status bit 7.
module frc_top #(
  parameter HAS_RESET_PIN = 0,
  parameter SECTORS = 4,
  parameter SECT_BITS = 2,
  parameter ADDR_BYTES = 3,
  parameter [23:0] SW_CYC = `FRC_STATUS_WRITE_CYC,
  parameter [23:0] NV_CYC = `FRC_NVCFG_WRITE_CYC
) (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire [3:0] dq_in,
  output reg [3:0] dq_out_q,
  output reg [3:0] dq_oe_q,
  input wire wp_n,
  input wire dual_mode,
  input wire quad_mode,
  input wire [SECT_BITS-1:0] pe_sector,
  output reg pe_blocked_q,
  output reg ready_q,
  output reg [7:0] vcr_q,
  output reg [7:0] evcr_q,
  output reg [7:0] ear_q,
  output reg [15:0] nvcr_q
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops per pin; only the second stage is looked at by logic.
  reg [6:0] s1_q;
  reg [6:0] s2_q;
  reg sclk_d1_q;
  always @(posedge clk) begin
    if (rst) begin
      s1_q <= 7'h7f;
      s2_q <= 7'h7f;
      sclk_d1_q <= 1'b0;
    end else begin
      s1_q <= {wp_n, cs_n, sclk, dq_in};
      s2_q <= s1_q;
      sclk_d1_q <= s2_q[4];
    end
  end
  wire cs_s = s2_q[5];
  wire sclk_s = s2_q[4];
  wire wp_s = s2_q[6];
  wire [3:0] din_s = s2_q[3:0];
  wire rise = sclk_s & ~sclk_d1_q;
  wire fall = ~sclk_s & sclk_d1_q;

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  localparam ST_CMD = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DOUT = 3'h2;
  localparam ST_DIN = 3'h3;
  localparam ST_IGN = 3'h4;

  reg [2:0] st_q;
  reg [7:0] cmd_q;     // Latched command code.
  reg [15:0] sh_q;     // Incoming shift register.
  reg [5:0] bits_q;    // Bits taken in the current field.
  reg [7:0] obyte_q;   // Byte being repeated out.
  reg [2:0] opos_q;    // Next output bit position.
  reg [7:0] sr_q;      // Status register.
  reg [SECTORS*2-1:0] lock_q; // Two lock bits per sector.
  reg [SECT_BITS-1:0] lsel_q; // Sector chosen by the lock address.
  reg [31:0] addr_q;
  reg cs_d1_q;

  // Address with the current clock's lines shifted in.
  // The sector must come from this value, since the last bits arrive on the final edge.
  wire [31:0] addr_nx = quad_mode ? {addr_q[27:0], din_s} :
                        dual_mode ? {addr_q[29:0], din_s[1:0]} : {addr_q[30:0], din_s[0]};

  // Lines per clock from the protocol mode.
  wire [2:0] step = quad_mode ? 3'h4 : (dual_mode ? 3'h2 : 3'h1);
  wire [5:0] step6 = {3'h0, step};

  // Shifted-in byte merged with the current clock's lines.
  reg [7:0] nb;
  // Upper byte of the sixteen-bit shift, so an earlier data byte survives.
  reg [7:0] nh;
  always @* begin
    case (step)
      3'h4: begin
        nb = {sh_q[3:0], din_s};
        nh = sh_q[11:4];
      end
      3'h2: begin
        nb = {sh_q[5:0], din_s[1:0]};
        nh = sh_q[13:6];
      end
      default: begin
        nb = {sh_q[6:0], din_s[0]};
        nh = sh_q[14:7];
      end
    endcase
  end

  // Timed busy flags from the shared counter.
  wire busy;
  reg tstart_q;
  reg [23:0] tload_q;
  frc_busy_timer #(.CW(24)) u_timer (
    .clk(clk),
    .rst(rst),
    .start(tstart_q),
    .load(tload_q),
    .busy_q(busy)
  );

  wire wel = sr_q[`FRC_SR_WEL_BIT];
  // Read value of the selected sector's lock byte; bits 7:2 forced zero.
  wire [7:0] lock_rd = {6'h00, lock_q[lsel_q*2 +: 2]};
  wire [7:0] fsr = {~busy, 7'h00};

  // Byte that a read command returns; one byte repeated for most.
  function [7:0] rd_byte;
    input [7:0] c;
    begin
      case (c)
        `FRC_CMD_RDSR: rd_byte = {sr_q[7:1], busy};
        `FRC_CMD_RDFSR: rd_byte = fsr;
        `FRC_CMD_RDVCR: rd_byte = vcr_q;
        `FRC_CMD_RDEVCR: rd_byte = evcr_q;
        `FRC_CMD_RDEAR: rd_byte = ear_q;
        `FRC_CMD_RDNVCR: rd_byte = nvcr_q[7:0];
        default: rd_byte = lock_rd;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Command, address and data phases
  // ----------------------------------------
  // One process owns the frame so that edge order is clear.
  always @(posedge clk) begin
    if (rst) begin
      st_q <= ST_CMD;
      cmd_q <= 8'h00;
      sh_q <= 16'h0000;
      bits_q <= 6'h00;
      obyte_q <= 8'h00;
      opos_q <= 3'h7;
      sr_q <= `FRC_SR_RST;
      vcr_q <= `FRC_VCR_RST;
      evcr_q <= `FRC_EVCR_RST;
      ear_q <= `FRC_EAR_RST;
      nvcr_q <= `FRC_NVCR_RST;
      lock_q <= {SECTORS*2{1'b0}};
      lsel_q <= {SECT_BITS{1'b0}};
      addr_q <= 32'h0;
      dq_out_q <= 4'h0;
      dq_oe_q <= 4'h0;
      cs_d1_q <= 1'b1;
      tstart_q <= 1'b0;
      tload_q <= 24'h0;
    end else begin
      cs_d1_q <= cs_s;
      tstart_q <= 1'b0;
      if (cs_s) begin
        // Deselected: release lines, start timed writes on the rising select.
        dq_oe_q <= 4'h0;
        st_q <= ST_CMD;
        bits_q <= 6'h00;
        if (!cs_d1_q && st_q == ST_DIN && wel && !busy) begin
          if (cmd_q == `FRC_CMD_WRSR && bits_q == 6'h08 && wp_s) begin
            sr_q <= (sr_q & ~`FRC_SR_WMASK) | (sh_q[7:0] & `FRC_SR_WMASK);
            sr_q[`FRC_SR_WEL_BIT] <= 1'b0;
            tload_q <= SW_CYC;
            tstart_q <= 1'b1;
          end else if (cmd_q == `FRC_CMD_WRNVCR && bits_q == 6'h10) begin
            nvcr_q <= {sh_q[7:0], sh_q[15:8]};
            sr_q[`FRC_SR_WEL_BIT] <= 1'b0;
            tload_q <= NV_CYC;
            tstart_q <= 1'b1;
          end
        end
      end else if (rise) begin
        case (st_q)
          ST_CMD: begin
            sh_q <= {8'h00, nb};
            if (bits_q + step6 >= 6'h08) begin
              bits_q <= 6'h00;
              cmd_q <= nb;
              case (nb)
                `FRC_CMD_WREN: begin
                  if (!busy) sr_q[`FRC_SR_WEL_BIT] <= 1'b1;
                  st_q <= ST_IGN;
                end
                `FRC_CMD_RDLOCK: st_q <= busy ? ST_IGN : ST_ADDR;
                `FRC_CMD_WRLOCK: st_q <= ST_ADDR;
                `FRC_CMD_RDSR, `FRC_CMD_RDFSR, `FRC_CMD_RDVCR, `FRC_CMD_RDEVCR,
                `FRC_CMD_RDEAR, `FRC_CMD_RDNVCR: begin
                  obyte_q <= rd_byte(nb);
                  opos_q <= 3'h7;
                  st_q <= ST_DOUT;
                end
                `FRC_CMD_WRSR, `FRC_CMD_WRNVCR, `FRC_CMD_WRVCR, `FRC_CMD_WREVCR,
                `FRC_CMD_WREAR: st_q <= ST_DIN;
                default: st_q <= ST_IGN;
              endcase
            end else begin
              bits_q <= bits_q + step6;
            end
          end
          ST_ADDR: begin
            // Address bits are taken on the rising clock edge.
            addr_q <= addr_nx;
            bits_q <= bits_q + step6;
            if (bits_q + step6 >= ADDR_BYTES * 8) begin
              bits_q <= 6'h00;
              lsel_q <= addr_nx[14 +: SECT_BITS];
              if (cmd_q == `FRC_CMD_RDLOCK) begin
                obyte_q <= {6'h00, lock_q[addr_nx[14 +: SECT_BITS]*2 +: 2]};
                opos_q <= 3'h7;
                st_q <= ST_DOUT;
              end else begin
                st_q <= ST_DIN;
              end
            end
          end
          ST_DIN: begin
            // Whole sixteen-bit shift: the first byte ends up in the upper half.
            sh_q <= {nh, nb};
            if ({3'h0, bits_q[2:0]} + step6 >= 6'h08) begin
              // Latch the first data byte only; immediate registers apply here.
              bits_q <= (bits_q[4:3] + 2'h1) == 2'h0 ? bits_q : {bits_q[5:3] + 3'h1, 3'h0};
              if (bits_q < 6'h08) begin
                if (wel && !busy) begin
                  case (cmd_q)
                    `FRC_CMD_WRVCR: begin
                      vcr_q <= (vcr_q & ~`FRC_VCR_WMASK) | (nb & `FRC_VCR_WMASK);
                      sr_q[`FRC_SR_WEL_BIT] <= 1'b0;
                    end
                    `FRC_CMD_WREVCR: begin
                      evcr_q <= nb;
                      sr_q[`FRC_SR_WEL_BIT] <= 1'b0;
                    end
                    `FRC_CMD_WRLOCK: begin
                      if (!lock_q[lsel_q*2 + `FRC_LOCK_DOWN_BIT])
                        lock_q[lsel_q*2 +: 2] <= nb[1:0];
                      sr_q[`FRC_SR_WEL_BIT] <= 1'b0;
                    end
                    default: ;
                  endcase
                end
                if (cmd_q == `FRC_CMD_WREAR && !busy &&
                    (wel || HAS_RESET_PIN != 0)) begin
                  ear_q <= (ear_q & ~`FRC_EAR_WMASK) | (nb & `FRC_EAR_WMASK);
                  sr_q[`FRC_SR_WEL_BIT] <= 1'b0;
                end
              end
            end else begin
              bits_q <= bits_q + step6;
            end
          end
          default: ;
        endcase
      end else if (fall && st_q == ST_DOUT) begin
        // Output changes on the falling edge; byte repeats while selected.
        if (step == 3'h4) begin
          dq_out_q <= opos_q[2] ? obyte_q[7:4] : obyte_q[3:0];
          dq_oe_q <= 4'hf;
          opos_q <= opos_q[2] ? 3'h3 : 3'h7;
        end else if (step == 3'h2) begin
          dq_out_q <= {2'h0, obyte_q[opos_q -: 2]};
          dq_oe_q <= 4'h3;
          opos_q <= opos_q - 3'h2;
        end else begin
          dq_out_q <= {2'h0, obyte_q[opos_q], 1'b0};
          dq_oe_q <= 4'h2;
          opos_q <= opos_q - 3'h1;
        end
        if (cmd_q == `FRC_CMD_RDSR || cmd_q == `FRC_CMD_RDFSR)
          obyte_q <= rd_byte(cmd_q);
      end
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Program/erase gating and ready both come from flops.
  always @(posedge clk) begin
    if (rst) begin
      pe_blocked_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      pe_blocked_q <= lock_q[pe_sector*2 + `FRC_LOCK_WRITE_BIT];
      ready_q <= ~busy;
    end
  end
endmodule

/* verification/frc_host_model.sv */
// Host SPI controller model that frames register commands for the flash block.
module frc_host_model (
  input wire logic clk,
  input wire logic [3:0] dq_w,
  input wire logic [3:0] dq_oe,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] h_val,
  output logic [3:0] h_oe,
  output logic oe_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  // Idle: deselected, serial clock low, lines released.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    h_val = 4'h0;
    h_oe = 4'h0;
    oe_seen = 1'b0;
  end
  // Each serial clock is eight system cycles, so edges are always seen.
  task automatic frame(input logic [7:0] cmd, input int w, input int nw, input logic [31:0] wd,
                       input int nr, output logic [7:0] r0, output logic [7:0] r1);
    logic [7:0] b;
    logic [7:0] r;
    int i;
    int k;
    r = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    oe_seen <= 1'b0;
    for (i = -1; i < nw + nr; i++) begin
      b = (i < 0) ? cmd : (i < nw) ? wd[8 * (nw - 1 - i) +: 8] : 8'h00;
      for (k = 0; k < 8 / w; k++) begin
        @(posedge clk);
        sclk <= 1'b0;
        h_val <= 4'(b >> (8 - w * (k + 1)));
        h_oe <= (i < nw) ? 4'(4'hf >> (4 - w)) : 4'h0;
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (3) @(posedge clk);
        // Read bits are taken late in the high phase, where they have settled.
        r = (w == 1) ? {r[6:0], dq_w[1]} : 8'((r << w) | (dq_w & 4'(4'hf >> (4 - w))));
        oe_seen <= oe_seen | (|dq_oe);
      end
      if (i == nw) r0 = r;
      r1 = r;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    h_oe <= 4'h0;
    @(posedge clk);
    sclk <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* verification/frc_checker_sva.sv */
// Concurrent checks on the pins and register outputs of the flash register block.
module frc_checker #(
  parameter [23:0] SW_CYC = 24'hc8,
  parameter [23:0] NV_CYC = 24'h258
) (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire dual_mode,
  input wire quad_mode,
  input wire [3:0] dq_oe_q,
  input wire ready_q,
  input wire [7:0] vcr_q,
  input wire [7:0] evcr_q,
  input wire [7:0] ear_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Busy length counter
  // ----------------------------------------
  // Counts cycles with the controller flag low; cleared while ready.
  logic [23:0] low_cnt_q;
  always @(posedge clk) begin
    if (rst || ready_q) low_cnt_q <= 24'h0;
    else low_cnt_q <= low_cnt_q + 24'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_release: assert property (cs_n [*6] |-> dq_oe_q == 4'h0)
    else $error("data lines driven while deselected");
  a_oe_needs_select: assert property ($rose(|dq_oe_q) |-> !cs_n && !$past(cs_n, 3))
    else $error("drive began without a select");
  a_single_lines: assert property (!dual_mode && !quad_mode && dq_oe_q != 4'h0 |-> dq_oe_q == 4'h2)
    else $error("single mode drives a line other than line one");
  a_dual_lines: assert property (dual_mode && !quad_mode && dq_oe_q != 4'h0 |-> dq_oe_q == 4'h3)
    else $error("dual mode line set wrong");
  a_quad_lines: assert property (quad_mode && dq_oe_q != 4'h0 |-> dq_oe_q == 4'hf)
    else $error("quad mode line set wrong");
  a_vcr_reserved: assert property (vcr_q[2] == 1'b0)
    else $error("reserved volatile bit changed");
  a_ear_reserved: assert property (ear_q[7:1] == 7'h00)
    else $error("reserved address bits changed");
  a_busy_deselect: assert property ($fell(ready_q) |-> cs_n && $past(cs_n, 2))
    else $error("timed write began while selected");
  a_busy_length: assert property ($rose(ready_q) |->
    low_cnt_q >= SW_CYC - 24'h2 && low_cnt_q <= NV_CYC + 24'h2)
    else $error("timed write length out of range");
  a_busy_frozen: assert property (!ready_q && $past(!ready_q) |->
    $stable(vcr_q) && $stable(evcr_q) && $stable(ear_q))
    else $error("register changed during a timed write");
endmodule

/* verification/frc_top_test.sv */
// Self-checking bench for the flash register command handler.
`include "frc_consts.vh"
module frc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic dual_mode = 1'b0;
  logic quad_mode = 1'b0;
  logic [1:0] pe_sector = 2'h0;
  logic junk_q = 1'b0;
  logic [3:0] dq_w, dq_out_q, dq_oe_q, h_val, h_oe;
  logic cs_n, sclk, oe_seen, pe_blocked_q, ready_q;
  logic [7:0] vcr_q, evcr_q, ear_q, r0, r1;
  logic [15:0] nvcr_q;
  int num_errors = 0;
  int checked = 0;
  int w = 1;
  always #50 clk = ~clk;
  // Released lines toggle so a stale value can never pass for data.
  always @(posedge clk) junk_q <= ~junk_q;
  assign dq_w = (dq_oe_q & dq_out_q) | (~dq_oe_q & h_oe & h_val) | (~dq_oe_q & ~h_oe & {4{junk_q}});
  // Short timed writes keep the run brief; expectations follow these values.
  frc_top #(.SW_CYC(24'hc8), .NV_CYC(24'h258)) u_dut (.clk(clk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .dq_in(dq_w), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q), .wp_n(wp_n),
    .dual_mode(dual_mode), .quad_mode(quad_mode), .pe_sector(pe_sector),
    .pe_blocked_q(pe_blocked_q), .ready_q(ready_q), .vcr_q(vcr_q), .evcr_q(evcr_q),
    .ear_q(ear_q), .nvcr_q(nvcr_q));
  frc_host_model u_host (.clk(clk), .dq_w(dq_w), .dq_oe(dq_oe_q), .cs_n(cs_n), .sclk(sclk),
    .h_val(h_val), .h_oe(h_oe), .oe_seen(oe_seen));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input int nw, input logic [31:0] wd, input int nr);
    u_host.frame(c, w, nw, wd, nr, r0, r1);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_q !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    // A timed write that never ends counts as a mismatch.
    if (ready_q !== 1'b1) begin
      num_errors++;
      $display("MISMATCH ready wait exp 1 got %b", ready_q);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("vcr rst", `FRC_VCR_RST, vcr_q);
    chk("evcr rst", `FRC_EVCR_RST, evcr_q);
    chk("ear rst", `FRC_EAR_RST, ear_q);
    chk("nvcr rst", `FRC_NVCR_RST, nvcr_q);
    chk("ready rst", 1'b1, ready_q);
    chk("lock rst", 1'b0, pe_blocked_q);
  endtask
  // Every line width; two bytes per read must match each other.
  task automatic t_reads();
    int m;
    for (m = 0; m < 3; m++) begin
      @(posedge clk);
      dual_mode <= (m == 1);
      quad_mode <= (m == 2);
      w = (m == 0) ? 1 : (m == 1) ? 2 : 4;
      cmd(`FRC_CMD_RDVCR, 0, 0, 2);
      chk("vcr rd", {8'h00, `FRC_VCR_RST}, {r0 ^ r1, r1});
      cmd(`FRC_CMD_RDEVCR, 0, 0, 2);
      chk("evcr rd", {8'h00, `FRC_EVCR_RST}, {r0 ^ r1, r1});
      cmd(`FRC_CMD_RDEAR, 0, 0, 2);
      chk("ear rd", {8'h00, `FRC_EAR_RST}, {r0 ^ r1, r1});
    end
    @(posedge clk);
    dual_mode <= 1'b0;
    quad_mode <= 1'b0;
    w = 1;
  endtask
  task automatic t_volatile();
    cmd(`FRC_CMD_WRVCR, 1, 32'h00, 0);
    chk("vcr no wel", `FRC_VCR_RST, vcr_q);
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WRVCR, 1, 32'h04, 0);
    chk("vcr wr", 8'h00, vcr_q);
    chk("ready vcr", 1'b1, ready_q);
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WREVCR, 1, 32'h5a, 0);
    chk("evcr wr", 8'h5a, evcr_q);
    cmd(`FRC_CMD_WREAR, 1, 32'hff, 0);
    chk("ear no wel", 8'h00, ear_q);
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WREAR, 1, 32'hff, 0);
    chk("ear wr", `FRC_EAR_WMASK, ear_q);
  endtask
  task automatic t_status();
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WRSR, 1, 32'hff, 0);
    cmd(`FRC_CMD_RDFSR, 0, 0, 1);
    chk("fsr busy", 1'b0, r0[`FRC_FSR_PEC_BIT]);
    wait_ready();
    repeat (2) begin
      cmd(`FRC_CMD_RDFSR, 0, 0, 1);
      chk("fsr done", 1'b1, r0[`FRC_FSR_PEC_BIT]);
    end
    cmd(`FRC_CMD_RDSR, 0, 0, 1);
    chk("sr wr", `FRC_SR_WMASK, r0);
    @(posedge clk);
    wp_n <= 1'b0;
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WRSR, 1, 32'h00, 0);
    chk("ready wp", 1'b1, ready_q);
    cmd(`FRC_CMD_RDSR, 0, 0, 1);
    chk("sr wp", `FRC_SR_WMASK, r0 & `FRC_SR_WMASK);
    @(posedge clk);
    wp_n <= 1'b1;
  endtask
  // The lock read lands inside the long timed write and must stay silent.
  task automatic t_nvcr();
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WRNVCR, 2, 32'h3412, 0);
    cmd(`FRC_CMD_RDLOCK, 3, 32'h008000, 1);
    chk("lock rd busy", 1'b0, oe_seen);
    chk("ready nv", 1'b0, ready_q);
    wait_ready();
    chk("nvcr wr", 16'h1234, nvcr_q);
    cmd(`FRC_CMD_RDNVCR, 0, 0, 2);
    chk("nvcr rd", 16'h3434, {r0, r1});
  endtask
  task automatic t_lock();
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WRLOCK, 4, 32'h008000fd, 0);
    cmd(`FRC_CMD_RDLOCK, 3, 32'h008000, 2);
    chk("lock rd", 16'h0101, {r0, r1});
    @(posedge clk);
    pe_sector <= 2'h2;
    repeat (3) @(posedge clk);
    chk("blk s2", 1'b1, pe_blocked_q);
    pe_sector <= 2'h1;
    repeat (3) @(posedge clk);
    chk("blk s1", 1'b0, pe_blocked_q);
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WRLOCK, 4, 32'h00800003, 0);
    cmd(`FRC_CMD_WREN, 0, 0, 0);
    cmd(`FRC_CMD_WRLOCK, 4, 32'h00800000, 0);
    cmd(`FRC_CMD_RDLOCK, 3, 32'h008000, 1);
    chk("lock down", 8'h03, r0);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_reads();
    t_volatile();
    t_status();
    t_nvcr();
    t_lock();
    close_out();
  end
  initial begin
    #4000000;
    num_errors++;
    close_out();
  end
endmodule
bind frc_top frc_checker #(.SW_CYC(SW_CYC), .NV_CYC(NV_CYC)) u_chk (.clk(clk), .rst(rst),
  .cs_n(cs_n), .dual_mode(dual_mode), .quad_mode(quad_mode), .dq_oe_q(dq_oe_q),
  .ready_q(ready_q), .vcr_q(vcr_q), .evcr_q(evcr_q), .ear_q(ear_q));
